// ---- core/hpi_pkg.sv ----
package hpi_pkg;

	// host interface modes held in the control register
	localparam logic [1:0] MODE_HARDWARE = 2'h0;
	localparam logic [1:0] MODE_SERIAL = 2'h1;
	localparam logic [1:0] MODE_PAR_DIRECT = 2'h2;
	localparam logic [1:0] MODE_PAR_MUX = 2'h3;

	// register byte offsets
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_IRQ_STATUS = 4'h4;
	localparam logic [3:0] OFS_IRQ_MASK = 4'h8;
	localparam logic [3:0] OFS_STRAP_STATUS = 4'hc;

	// control fields
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_IRQ_DRIVE_HIGH = 2;
	localparam int CTRL_SOFT_RESET = 3;
	localparam logic [1:0] CTRL_MODE_RESET = MODE_HARDWARE;

	// interrupt source bits
	localparam int IRQ_BITS = 3;
	localparam int IRQ_READ_DONE = 0;
	localparam int IRQ_WRITE_DONE = 1;
	localparam int IRQ_STRAP_CHANGE = 2;
	localparam logic [2:0] IRQ_MASK_RESET = 3'h0;

	// strap status fields
	localparam int STRAP_TERM_OFF_BIT = 16;

	// pad comparator level codes of a three-level strap
	localparam logic [1:0] LVL_LOW = 2'h0;
	localparam logic [1:0] LVL_MID = 2'h1;

	// decoded loopback selections
	localparam logic [1:0] LB_NONE = 2'h0;
	localparam logic [1:0] LB_REMOTE = 2'h1;
	localparam logic [1:0] LB_ANALOG = 2'h2;

	// timing
	localparam int CLK_PERIOD_NS = 8;
	localparam int DEBOUNCE_NS = 10000;
	localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// host port geometry
	localparam int HOST_AW = 6;
	localparam int HOST_DW = 8;
	localparam int CHANNELS = 8;

	typedef struct packed {
		logic we;
		logic [HOST_AW-1:0] addr;
		logic [HOST_DW-1:0] wdata;
	} hpi_ram_req_t;

	typedef enum logic [2:0] {
		HP_IDLE = 3'b001,
		HP_READ = 3'b010,
		HP_ACK = 3'b100
	} hpi_host_state_t;

endpackage : hpi_pkg

// ---- core/hpi_ram.sv ----
`timescale 1ns/1ns
`default_nettype none

// byte store behind the parallel host port, registered read data
module hpi_ram
	import hpi_pkg::*;
(
	// clock
	input wire logic clk,
	// access
	input wire hpi_ram_req_t req,
	output logic [HOST_DW-1:0] rdata
);

	logic [HOST_DW-1:0] mem [2**HOST_AW];

	always_ff @(posedge clk)
	begin
		if (req.we)
		begin
			mem[req.addr] <= req.wdata;
		end
		rdata <= mem[req.addr];
	end

endmodule : hpi_ram

`default_nettype wire

// ---- core/hpi_top.sv ----
// Behaviour
// - strobe mode: ack low when read/write done
// - hardware mode: termination-off strap disables rx termination
// - interrupt pin low on any enabled event
// - idle interrupt pin driven high or floating, floating default
// - software reset disables every interrupt source
// - direct mode: data pins form bidirectional bus
// - mux mode: address from six low bits only
// - hardware mode: loopback strap low remote, mid none, high analog
`timescale 1ns/1ns
`default_nettype none

module hpi_top
	import hpi_pkg::*;
#(
	parameter int DEBOUNCE_LEN = DEBOUNCE_CYCLES
)
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [3:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// parallel host strobes
	input wire logic HOST_DS_N,
	input wire logic HOST_RW,
	input wire logic HOST_AS_N,
	input wire logic [HOST_AW-1:0] HOST_ADDR,
	output logic TRANSFER_ACK_N,
	// shared data pins
	input wire logic [HOST_DW-1:0] DATA_IN,
	output logic [HOST_DW-1:0] DATA_OUT,
	output logic DATA_OE_N,
	// straps
	input wire logic [2*CHANNELS-1:0] LOOPBACK_STRAP_LVL,
	input wire logic RX_TERMINATION_OFF,
	output logic [2*CHANNELS-1:0] LOOPBACK_MODE,
	output logic RX_TERM_OFF,
	// interrupt
	output logic IRQ_OUT_N,
	output logic IRQ_OUT_OE_N,
	output logic IRQ
);

	localparam int NSTRAP = CHANNELS + 1;

	if (DEBOUNCE_LEN < 1 || DEBOUNCE_LEN > 65535)
	begin : g_bad_debounce
		$error("debounce length out of range");
	end

	// register file and bus slave
	logic [1:0] mode_reg, mode_next;
	logic drive_high_reg, drive_high_next;
	logic [IRQ_BITS-1:0] status_reg, status_next;
	logic [IRQ_BITS-1:0] mask_reg, mask_next;
	logic wb_ack_reg, wb_ack_next;
	logic [31:0] wb_dat_reg, wb_dat_next;
	logic irq_reg, irq_next;
	logic irq_pin_reg, irq_pin_next;
	logic irq_oe_n_reg, irq_oe_n_next;
	logic [IRQ_BITS-1:0] events;
	logic [31:0] strap_word;
	logic wr_fire;

	// host port
	hpi_host_state_t state_reg, state_next;
	logic ds_d_reg, as_d_reg;
	logic [HOST_AW-1:0] mux_addr_reg, mux_addr_next;
	logic [HOST_AW-1:0] cur_addr_reg, cur_addr_next;
	logic ack_n_reg, ack_n_next;
	logic [HOST_DW-1:0] dout_reg, dout_next;
	logic doe_n_reg, doe_n_next;
	logic rd_done, wr_done;
	logic parallel;
	hpi_ram_req_t ram_req;
	logic [HOST_DW-1:0] ram_rdata;

	// straps
	logic [1:0] strap_raw [NSTRAP];
	logic [1:0] strap_stable [NSTRAP];
	logic [2*CHANNELS-1:0] lb_next;
	logic lb_change;
	logic [2*CHANNELS-1:0] lb_reg;
	logic term_reg, term_next;

	assign parallel = (mode_reg == MODE_PAR_DIRECT) || (mode_reg == MODE_PAR_MUX);
	assign wr_fire = WB_CYC_I && WB_STB_I && WB_WE_I && !wb_ack_reg && WB_SEL_I[0];
	assign strap_word = {15'h0000, term_reg, lb_reg};
	assign events = {lb_change, wr_done, rd_done};

	always_comb
	begin
		mode_next = mode_reg;
		drive_high_next = drive_high_reg;
		mask_next = mask_reg;
		status_next = status_reg;
		wb_dat_next = wb_dat_reg;
		wb_ack_next = WB_CYC_I && WB_STB_I && !wb_ack_reg;
		if (wr_fire && WB_ADR_I == OFS_CTRL)
		begin
			mode_next = WB_DAT_I[CTRL_MODE_LSB +: 2];
			drive_high_next = WB_DAT_I[CTRL_IRQ_DRIVE_HIGH];
		end
		if (wr_fire && WB_ADR_I == OFS_IRQ_MASK)
		begin
			mask_next = WB_DAT_I[IRQ_BITS-1:0];
		end
		if (wr_fire && WB_ADR_I == OFS_IRQ_STATUS)
		begin
			status_next = status_reg & ~WB_DAT_I[IRQ_BITS-1:0];
		end
		if (wr_fire && WB_ADR_I == OFS_CTRL && WB_DAT_I[CTRL_SOFT_RESET])
		begin
			mask_next = IRQ_MASK_RESET;
			status_next = '0;
		end
		status_next = status_next | events;
		if (WB_CYC_I && WB_STB_I && !wb_ack_reg)
		begin
			case (WB_ADR_I)
				OFS_CTRL: wb_dat_next = {28'h0000000, 1'b0, drive_high_reg, mode_reg};
				OFS_IRQ_STATUS: wb_dat_next = {29'h00000000, status_reg};
				OFS_IRQ_MASK: wb_dat_next = {29'h00000000, mask_reg};
				OFS_STRAP_STATUS: wb_dat_next = strap_word;
				default: wb_dat_next = 32'h00000000;
			endcase
		end
		irq_next = |(status_reg & mask_reg);
		irq_pin_next = !irq_next;
		irq_oe_n_next = !(irq_next || drive_high_reg);
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			mode_reg <= CTRL_MODE_RESET;
			drive_high_reg <= 1'b0;
			mask_reg <= IRQ_MASK_RESET;
			status_reg <= '0;
			wb_ack_reg <= 1'b0;
			wb_dat_reg <= 32'h00000000;
			irq_reg <= 1'b0;
			irq_pin_reg <= 1'b1;
			irq_oe_n_reg <= 1'b1;
		end
		else
		begin
			mode_reg <= mode_next;
			drive_high_reg <= drive_high_next;
			mask_reg <= mask_next;
			status_reg <= status_next;
			wb_ack_reg <= wb_ack_next;
			wb_dat_reg <= wb_dat_next;
			irq_reg <= irq_next;
			irq_pin_reg <= irq_pin_next;
			irq_oe_n_reg <= irq_oe_n_next;
		end
	end

	// parallel host port state machine
	always_comb
	begin
		state_next = state_reg;
		mux_addr_next = mux_addr_reg;
		cur_addr_next = cur_addr_reg;
		ack_n_next = ack_n_reg;
		dout_next = dout_reg;
		doe_n_next = doe_n_reg;
		rd_done = 1'b0;
		wr_done = 1'b0;
		ram_req.we = 1'b0;
		ram_req.addr = cur_addr_reg;
		ram_req.wdata = DATA_IN;
		if (mode_reg == MODE_PAR_MUX && as_d_reg && !HOST_AS_N)
		begin
			mux_addr_next = DATA_IN[HOST_AW-1:0];
		end
		case (state_reg)
			HP_IDLE:
			begin
				if (parallel && ds_d_reg && !HOST_DS_N)
				begin
					cur_addr_next = (mode_reg == MODE_PAR_MUX) ? mux_addr_reg : HOST_ADDR;
					ram_req.addr = cur_addr_next;
					if (HOST_RW)
					begin
						state_next = HP_READ;
					end
					else
					begin
						ram_req.we = 1'b1;
						ack_n_next = 1'b0;
						wr_done = 1'b1;
						state_next = HP_ACK;
					end
				end
			end
			HP_READ:
			begin
				dout_next = ram_rdata;
				doe_n_next = 1'b0;
				ack_n_next = 1'b0;
				rd_done = 1'b1;
				state_next = HP_ACK;
			end
			HP_ACK:
			begin
				if (HOST_DS_N || !parallel)
				begin
					ack_n_next = 1'b1;
					doe_n_next = 1'b1;
					state_next = HP_IDLE;
				end
			end
			default:
			begin
				ack_n_next = 1'b1;
				doe_n_next = 1'b1;
				state_next = HP_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			state_reg <= HP_IDLE;
			ds_d_reg <= 1'b1;
			as_d_reg <= 1'b1;
			mux_addr_reg <= '0;
			cur_addr_reg <= '0;
			ack_n_reg <= 1'b1;
			dout_reg <= '0;
			doe_n_reg <= 1'b1;
		end
		else
		begin
			state_reg <= state_next;
			ds_d_reg <= HOST_DS_N;
			as_d_reg <= HOST_AS_N;
			mux_addr_reg <= mux_addr_next;
			cur_addr_reg <= cur_addr_next;
			ack_n_reg <= ack_n_next;
			dout_reg <= dout_next;
			doe_n_reg <= doe_n_next;
		end
	end

	hpi_ram u_ram (
		.clk(CLOCK),
		.req(ram_req),
		.rdata(ram_rdata)
	);

	// strap synchroniser and debounce per strap
	for (genvar i = 0; i < NSTRAP; i++)
	begin : g_strap
		logic [1:0] s1_reg, s2_reg, cand_reg, cand_next, stab_reg, stab_next;
		logic [15:0] cnt_reg, cnt_next;
		// termination strap idles low, loopback straps idle at mid supply
		localparam logic [1:0] RST_LVL = (i < CHANNELS) ? LVL_MID : LVL_LOW;
		if (i < CHANNELS)
		begin : g_lb
			assign strap_raw[i] = LOOPBACK_STRAP_LVL[2*i +: 2];
		end
		else
		begin : g_term
			assign strap_raw[i] = {1'b0, RX_TERMINATION_OFF};
		end
		assign strap_stable[i] = stab_reg;
		always_comb
		begin
			cand_next = cand_reg;
			cnt_next = cnt_reg;
			stab_next = stab_reg;
			if (s2_reg != cand_reg)
			begin
				cand_next = s2_reg;
				cnt_next = 16'h0000;
			end
			else if (cnt_reg == 16'(DEBOUNCE_LEN - 1))
			begin
				stab_next = cand_reg;
			end
			else
			begin
				cnt_next = cnt_reg + 16'h0001;
			end
		end
		always_ff @(posedge CLOCK)
		begin
			if (SYS_RST)
			begin
				s1_reg <= RST_LVL;
				s2_reg <= RST_LVL;
				cand_reg <= RST_LVL;
				stab_reg <= RST_LVL;
				cnt_reg <= 16'h0000;
			end
			else
			begin
				s1_reg <= strap_raw[i];
				s2_reg <= s1_reg;
				cand_reg <= cand_next;
				stab_reg <= stab_next;
				cnt_reg <= cnt_next;
			end
		end
	end

	// strap decode, applied only in hardware mode
	always_comb
	begin
		lb_next = '0;
		for (int c = 0; c < CHANNELS; c++)
		begin
			if (mode_reg != MODE_HARDWARE)
			begin
				lb_next[2*c +: 2] = LB_NONE;
			end
			else if (strap_stable[c] == LVL_LOW)
			begin
				lb_next[2*c +: 2] = LB_REMOTE;
			end
			else if (strap_stable[c] == LVL_MID)
			begin
				lb_next[2*c +: 2] = LB_NONE;
			end
			else
			begin
				lb_next[2*c +: 2] = LB_ANALOG;
			end
		end
		term_next = (mode_reg == MODE_HARDWARE) && strap_stable[CHANNELS][0];
		lb_change = (lb_next != lb_reg) || (term_next != term_reg);
	end

	always_ff @(posedge CLOCK)
	begin
		if (SYS_RST)
		begin
			lb_reg <= '0;
			term_reg <= 1'b0;
		end
		else
		begin
			lb_reg <= lb_next;
			term_reg <= term_next;
		end
	end

	assign WB_DAT_O = wb_dat_reg;
	assign WB_ACK_O = wb_ack_reg;
	assign TRANSFER_ACK_N = ack_n_reg;
	assign DATA_OUT = dout_reg;
	assign DATA_OE_N = doe_n_reg;
	assign LOOPBACK_MODE = lb_reg;
	assign RX_TERM_OFF = term_reg;
	assign IRQ_OUT_N = irq_pin_reg;
	assign IRQ_OUT_OE_N = irq_oe_n_reg;
	assign IRQ = irq_reg;

endmodule : hpi_top

`default_nettype wire

// ---- bench/hpi_properties.sv ----
`timescale 1ns/1ns
`default_nettype none
module hpi_properties
	import hpi_pkg::*;
(
	// clock and reset
	input wire logic CLOCK,
	input wire logic SYS_RST,
	// host port
	input wire logic HOST_DS_N,
	input wire logic HOST_RW,
	input wire logic TRANSFER_ACK_N,
	input wire logic DATA_OE_N,
	// straps
	input wire logic RX_TERMINATION_OFF,
	input wire logic RX_TERM_OFF,
	input wire logic [2*CHANNELS-1:0] LOOPBACK_MODE,
	// interrupt
	input wire logic IRQ_OUT_N,
	input wire logic IRQ_OUT_OE_N,
	input wire logic IRQ
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (SYS_RST);
	logic bad_code;
	assign bad_code = |(LOOPBACK_MODE & (LOOPBACK_MODE >> 1) & 16'h5555);
	AST_ACK_SRC: assert property ($fell(TRANSFER_ACK_N) |-> !HOST_DS_N && !$past(HOST_DS_N))
		else $error("ack without strobe");
	AST_ACK_REL: assert property (HOST_DS_N [*2] |=> TRANSFER_ACK_N && DATA_OE_N)
		else $error("ack or data held after strobe");
	AST_RD_DRIVE: assert property ($fell(DATA_OE_N) |-> !TRANSFER_ACK_N && HOST_RW)
		else $error("data driven outside read");
	AST_IRQ_PIN: assert property (IRQ |-> !IRQ_OUT_N && !IRQ_OUT_OE_N)
		else $error("irq pin not low");
	AST_IRQ_IDLE: assert property (!IRQ |-> IRQ_OUT_N)
		else $error("idle irq pin low");
	AST_IRQ_FLOAT: assert property ($fell(SYS_RST) |-> IRQ_OUT_OE_N && !IRQ)
		else $error("irq pin driven after reset");
	AST_TERM: assert property ($rose(RX_TERM_OFF) |-> $past(RX_TERMINATION_OFF, 4))
		else $error("termination off without steady strap");
	AST_LB_CODE: assert property (!bad_code)
		else $error("bad loopback code");
endmodule : hpi_properties
bind hpi_top hpi_properties i_props (.CLOCK, .SYS_RST, .HOST_DS_N, .HOST_RW,
	.TRANSFER_ACK_N, .DATA_OE_N, .RX_TERMINATION_OFF, .RX_TERM_OFF, .LOOPBACK_MODE,
	.IRQ_OUT_N, .IRQ_OUT_OE_N, .IRQ);
`default_nettype wire

// ---- bench/hpi_host_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module hpi_host_model
	import hpi_pkg::*;
(
	// from device
	input wire logic clk,
	input wire logic ack_n,
	input wire logic oe_n,
	input wire logic [HOST_DW-1:0] dout,
	// to device
	output logic ds_n = 1'b1,
	output logic rw = 1'b1,
	output logic as_n = 1'b1,
	output logic [HOST_AW-1:0] addr = 6'h00,
	output logic [HOST_DW-1:0] pin
);
	logic drv = 1'b0;
	logic serial = 1'b0;
	logic [HOST_DW-1:0] hd = 8'h00;
	logic [HOST_DW-1:0] pat = 8'h5a;
	always @(posedge clk) pat <= ~pat;
	// released pins toggle; serial mode holds them low
	assign pin = serial ? 8'h00 : !oe_n ? dout : drv ? hd : pat;
	task automatic xfer(input logic r, input logic mux, input logic [7:0] a,
		input logic [7:0] d, output logic [7:0] q, output int ok);
		int n;
		ok = 0;
		if (mux)
		begin
			@(posedge clk);
			hd <= a;
			drv <= 1'b1;
			as_n <= 1'b0;
			@(posedge clk);
			as_n <= 1'b1;
		end
		@(posedge clk);
		addr <= mux ? 6'h00 : a[5:0];
		rw <= r;
		hd <= d;
		drv <= !r;
		ds_n <= 1'b0;
		for (n = 0; n < 20 && ok == 0; n++)
		begin
			@(posedge clk);
			if (ack_n === 1'b0) ok = 1;
		end
		q = pin;
		ds_n <= 1'b1;
		drv <= 1'b0;
		for (n = 0; n < 20 && ok == 1; n++)
		begin
			@(posedge clk);
			if (ack_n === 1'b1) ok = 2;
		end
	endtask : xfer
endmodule : hpi_host_model
`default_nettype wire

// ---- bench/testbench.sv ----
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import hpi_pkg::*;
	logic CLOCK = 1'b0;
	logic SYS_RST = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, term = 1'b0;
	logic [3:0] adr = 4'h0;
	logic [31:0] wdat = 32'h0, rdat, rd;
	logic [15:0] strap = 16'h5555, lbm;
	logic [7:0] dout, pin, q;
	logic [5:0] haddr;
	logic ack, tack_n, oe_n, term_o, irq_n, irq_oe_n, irq, ds_n, rw, as_n;
	int error_cnt = 0, cmp_count = 0, cycles = 0, ok;
	hpi_top #(.DEBOUNCE_LEN(4)) i_dut (.CLOCK(CLOCK), .SYS_RST(SYS_RST), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat),
		.WB_DAT_O(rdat), .WB_ACK_O(ack), .HOST_DS_N(ds_n), .HOST_RW(rw), .HOST_AS_N(as_n),
		.HOST_ADDR(haddr), .TRANSFER_ACK_N(tack_n), .DATA_IN(pin), .DATA_OUT(dout),
		.DATA_OE_N(oe_n), .LOOPBACK_STRAP_LVL(strap), .RX_TERMINATION_OFF(term),
		.LOOPBACK_MODE(lbm), .RX_TERM_OFF(term_o), .IRQ_OUT_N(irq_n),
		.IRQ_OUT_OE_N(irq_oe_n), .IRQ(irq));
	hpi_host_model i_host (.clk(CLOCK), .ack_n(tack_n), .oe_n(oe_n), .dout(dout),
		.ds_n(ds_n), .rw(rw), .as_n(as_n), .addr(haddr), .pin(pin));
	initial forever #4 CLOCK = ~CLOCK;
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			$display("[ERR] %s exp %h got %h", nm, exp, got);
			error_cnt++;
		end
	endtask : chk
	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge CLOCK);
		{cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
		n = 0;
		do
		begin
			@(posedge CLOCK);
			n++;
		end while (ack !== 1'b1 && n < 20);
		rd = rdat;
		{cyc, stb} <= 2'b00;
		chk("wb ack", ack, 1);
	endtask : wb
	task automatic t_reset;
		wb(0, OFS_CTRL, 0);
		chk("ctrl", rd, 0);
		wb(0, OFS_IRQ_MASK, 0);
		chk("mask", rd, 0);
		wb(0, 4'h2, 0);
		chk("unmapped", rd, 0);
		chk("irq oe", irq_oe_n, 1);
		$display("t_reset done");
	endtask : t_reset
	task automatic t_direct;
		wb(1, OFS_CTRL, 32'h2);
		wb(1, OFS_IRQ_MASK, 32'h3);
		i_host.xfer(0, 0, 8'h05, 8'ha7, q, ok);
		chk("wr ack", ok, 2);
		i_host.xfer(1, 0, 8'h05, 8'h00, q, ok);
		chk("rd data", q, 8'ha7);
		chk("irq", irq, 1);
		chk("irq pin", irq_n, 0);
		wb(0, OFS_IRQ_STATUS, 0);
		chk("status", rd, 3);
		wb(1, OFS_IRQ_STATUS, 3);
		repeat (3) @(posedge CLOCK);
		chk("irq clr", irq, 0);
		chk("float", irq_oe_n, 1);
		wb(1, OFS_CTRL, 32'h6);
		repeat (3) @(posedge CLOCK);
		chk("drive hi", {irq_oe_n, irq_n}, 1);
		$display("t_direct done");
	endtask : t_direct
	task automatic t_mux;
		wb(1, OFS_CTRL, 32'h3);
		i_host.xfer(0, 1, 8'hc9, 8'h3c, q, ok);
		i_host.xfer(1, 1, 8'h09, 8'h00, q, ok);
		chk("mux rd", q, 8'h3c);
		i_host.xfer(1, 1, 8'h45, 8'h00, q, ok);
		chk("mux top", q, 8'ha7);
		$display("t_mux done");
	endtask : t_mux
	task automatic t_soft;
		wb(1, OFS_IRQ_MASK, 32'h7);
		wb(1, OFS_CTRL, 32'ha);
		wb(0, OFS_IRQ_MASK, 0);
		chk("mask sr", rd, 0);
		i_host.xfer(0, 0, 8'h01, 8'h11, q, ok);
		repeat (3) @(posedge CLOCK);
		chk("irq sr", irq, 0);
		wb(1, OFS_IRQ_MASK, 32'h2);
		repeat (3) @(posedge CLOCK);
		chk("irq en", irq, 1);
		wb(1, OFS_CTRL, 32'h1);
		i_host.serial <= 1'b1;
		i_host.xfer(0, 0, 8'h02, 8'h22, q, ok);
		chk("serial", ok, 0);
		i_host.serial <= 1'b0;
		$display("t_soft done");
	endtask : t_soft
	task automatic t_strap;
		wb(1, OFS_CTRL, 0);
		@(posedge CLOCK);
		strap <= 16'h55e4;
		term <= 1'b1;
		@(posedge CLOCK);
		@(posedge CLOCK);
		chk("lb early", lbm, 0);
		repeat (20) @(posedge CLOCK);
		chk("lb", lbm, 16'h00a1);
		chk("term", term_o, 1);
		wb(0, OFS_STRAP_STATUS, 0);
		chk("strap st", rd, 32'h100a1);
		wb(0, OFS_IRQ_STATUS, 0);
		chk("strap ev", rd, 32'h6);
		$display("t_strap done");
	endtask : t_strap
	task automatic wrap_up;
		$display("checks %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : wrap_up
	always @(posedge CLOCK)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			error_cnt++;
			wrap_up;
		end
	end
	initial
	begin
		repeat (8) @(posedge CLOCK);
		SYS_RST <= 1'b0;
		t_reset;
		t_direct;
		t_mux;
		t_soft;
		t_strap;
		wrap_up;
	end
endmodule : testbench
`default_nettype wire
